//--- pkg/prot_charger_defs.svh
// Purpose: offsets, field positions, reset values and timing for the protection register bank
// Assumes: 8-bit registers behind an I2C target; REF_CLK period of 8 ns
// Notes:   widths match the fields they meet
`ifndef PROT_CHARGER_DEFS_SVH
`define PROT_CHARGER_DEFS_SVH

`define REG_STATUS      4'h0
`define REG_CONFIG      4'h1
`define REG_CHGCTL      4'h2
`define REG_CHGSTS      4'h3
`define REG_LAST        8'h03
`define ADDR_FIXED      5'h1A
`define UNMAPPED_DATA   8'hFF
`define CFG_RESET       8'h20
`define CTL_RESET       8'h00
`define STS_CHANGE_MASK 8'hFD
`define STS_RESET       8'h05

`define CFG_SW_EN       0
`define CFG_LIM_EN      1
`define CFG_SW_OVR      2
`define CFG_LIM_OVR     3
`define CFG_PATH1       5
`define CFG_PATH2       6
`define CFG_RESTART     7
`define CTL_MANUAL      7

`define CODE_DCP        3'h1
`define CODE_CDP        3'h2

`define REF_PERIOD_NS   8
`define INT_HOLD_NS     1000000
`define SOFT_POR_NS     100000

`endif

//--- pkg/prot_charger_pkg.sv
// Purpose: types for the protection register bank
// Assumes: nothing
// Notes:   one state struct per clock domain
package prot_charger_pkg;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_REG  = 3'b010,
      PH_WDAT = 3'b011,
      PH_RDAT = 3'b100,
      PH_SKIP = 3'b101
   } phase_t;

   typedef struct packed {
      logic       scl_m, scl_s, scl_p;
      logic       sda_m, sda_s, sda_p;
      logic [1:0] otp_m, otp_s;
      logic [7:0] sts_m, sts_s;
      logic [7:0] chs_m, chs_s;
      logic       done_m, done_s, done_p;
      phase_t     phase;
      phase_t     nxt;
      logic [3:0] bitcnt;
      logic       ack;
      logic       rw;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [7:0] regaddr;
      logic       drive;
      logic [7:0] cfg;
      logic [7:0] ctl;
      logic       rd_tgl;
   } link_state_t;

   typedef struct packed {
      logic [18:0] in_m, in_s;
      logic [7:0]  cfg_m, cfg_s;
      logic [7:0]  ctl_m, ctl_s;
      logic        rd_m, rd_s, rd_p;
      logic        ovlo_p;
      logic        latch;
      logic [7:0]  status;
      logic [7:0]  chsts;
      logic        int_low;
      logic [23:0] int_cnt;
      logic        sr_busy;
      logic        sr_wait;
      logic [23:0] sr_cnt;
      logic        done_tgl;
      logic        sw_en;
      logic        lim_on;
      logic        path1;
      logic        path2;
      logic [6:0]  chg_out;
   } ref_state_t;

endpackage : prot_charger_pkg

//--- sim/i2c_host_model.sv
// Purpose: I2C master standing in for the host controller
// Assumes: SDA wire is resolved outside with a pull-up
// Notes:   sda moves mid-low except at start and stop, so the target never sees a false start or stop
`timescale 1ns/100ps
module i2c_host_model #(
   parameter int HALF = 12
) (
   input  wire logic clk,
   input  wire logic sda,
   output      logic scl = 1'b1,
   output      logic sda_oe_n = 1'b1
);
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   task automatic start();
      scl = 1'b1;
      wt(HALF);
      sda_oe_n = 1'b0;
      wt(HALF);
      scl = 1'b0;
   endtask : start
   task automatic stop();
      wt(HALF / 2);
      sda_oe_n = 1'b0;
      wt(HALF / 2);
      scl = 1'b1;
      wt(HALF);
      sda_oe_n = 1'b1;
      wt(HALF);
   endtask : stop
   // eight bits msb first, then the acknowledge slot; a one releases the wire
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                       output logic ar);
      logic [8:0] o;
      logic [8:0] i;
      o = {tx, ak};
      for (int k = 8; k >= 0; k--) begin
         wt(HALF / 2);
         sda_oe_n = o[k];
         wt(HALF / 2);
         scl = 1'b1;
         wt(HALF);
         i[k] = sda;
         scl = 1'b0;
      end
      rx = i[8:1];
      ar = i[0];
   endtask : xfer
endmodule : i2c_host_model

//--- sim/tb_prot_charger_regs.sv
// Purpose: self-checking bench for the protection register bank
// Assumes: host model drives the link; SDA has a pull-up
// Notes:   short hold and restart counts keep the run brief
`timescale 1ns/100ps
`include "prot_charger_defs.svh"
module tb_prot_charger_regs;
   localparam int HOLD = 2000;
   localparam int POR  = 10;
   logic       ref_clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst;
   logic       ovlo;
   logic       done;
   logic       ext;
   logic       auto_sw;
   logic       auto_lim;
   logic [1:0] otp;
   logic [2:0] code;
   logic [3:0] chs_in;
   logic [6:0] auto_ctl;
   logic [6:0] dev = {`ADDR_FIXED, 2'h0};
   logic [7:0] d;
   logic [7:0] r;
   logic       a;
   logic [7:0] cv [6] = '{8'h05, 8'h04, 8'h01, 8'h08, 8'h0D, 8'h0A};
   logic [1:0] sl [6] = '{2'b11, 2'b01, 2'b11, 2'b10, 2'b10, 2'b11};
   wire        scl, host_oe_n, sda_o, sda_oe_n, int_o, int_oe_n, sw, lim, p1, p2, restart;
   wire  [6:0] ctl_out;
   wire        sda = host_oe_n & sda_oe_n;
   int         fail_count = 0;
   int         checks = 0;
   int         cyc = 0;
   int         por_cnt = 0;
   int         n = 0;
   always #4 ref_clk = ~ref_clk;
   initial #3.3 forever #7.5 link_clk = ~link_clk;
   i2c_host_model host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n));
   prot_charger_regs #(.INT_HOLD_CYC(HOLD), .SOFT_POR_CYC(POR)) uut (
      .REF_CLK(ref_clk), .RST(rst), .LINK_CLK(link_clk), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .INT_O(int_o), .INT_OE_N(int_oe_n),
      .OTP_ADDR(otp), .OVERVOLTAGE_COMPARATOR_FLAG(ovlo), .DETECTION_DONE_FLAG(done),
      .DETECTED_PORT_CODE(code), .EXTENDED_DETECTION_OPTION(ext),
      .AUTO_SWITCH_ENABLE(auto_sw), .AUTO_LIMIT_ENABLE(auto_lim),
      .AUTO_CHARGER_CONTROL(auto_ctl), .CHARGER_STATUS_IN(chs_in),
      .PROTECTION_SWITCH_ENABLE(sw), .LIMIT_ACTIVE(lim), .FIRST_PATH_ENABLE(p1),
      .SECOND_PATH_ENABLE(p2), .CHARGER_CONTROL(ctl_out), .DETECTION_RESTART(restart));
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (restart === 1'b1)
         por_cnt <= por_cnt + 1;
      if (cyc == 90000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
      logic a1, a2, a3;
      host.start();
      host.xfer({dev, 1'b0}, 1'b1, r, a1);
      host.xfer(ra, 1'b1, r, a2);
      host.xfer(wd, 1'b1, r, a3);
      host.stop();
      chk("write acks", 8'h00, {5'h0, a1, a2, a3});
   endtask : wr
   task automatic rchk(input string nm, input logic [7:0] ra, input logic [7:0] e);
      logic a1, a2, a3;
      host.start();
      host.xfer({dev, 1'b1}, 1'b1, r, a1);
      host.xfer(ra, 1'b1, r, a2);
      host.xfer(8'hFF, 1'b1, d, a3);
      host.stop();
      chk("read acks", 8'h00, {6'h0, a1, a2});
      chk(nm, e, d);
   endtask : rchk
   initial begin
      rst = 1'b1;
      ovlo = 1'b1;
      done = 1'b0;
      ext = 1'b0;
      auto_sw = 1'b0;
      auto_lim = 1'b0;
      otp = 2'h0;
      code = 3'h0;
      chs_in = 4'h0;
      auto_ctl = 7'h2A;
      host.wt(16);
      rst = 1'b0;
      host.wt(8);
      rchk("status", 8'h00, 8'h05);
      rchk("status", 8'h00, 8'h05);
      rchk("config", 8'h01, 8'h20);
      rchk("control", 8'h02, 8'h00);
      rchk("chg status", 8'h03, 8'h00);
      for (int i = 0; i < 4; i++) begin
         otp = 2'(i);
         dev = {`ADDR_FIXED, otp};
         host.wt(8);
         rchk("config", 8'h01, 8'h20);
         host.start();
         host.xfer({`ADDR_FIXED, ~otp, 1'b0}, 1'b1, r, a);
         host.stop();
         chk("foreign ack", 8'h01, {7'h0, a});
      end
      auto_lim = 1'b1;
      auto_sw = 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(8'h01, cv[i]);
         chk("switch limit", {6'h0, sl[i]}, {6'h0, sw, lim});
         rchk("status", 8'h00, {4'h0, sl[i][0], ~sl[i][1], 2'b01});
      end
      auto_sw = 1'b0;
      done = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'h01, {1'b0, 2'(i), 5'h0});
         chk("paths", 8'(i), {6'h0, p2, p1});
      end
      for (int i = 1; i < 7; i++) begin
         ext = (i == 6);
         code = (i == 6) ? 3'h2 : 3'(i);
         host.wt(6);
         rchk("status", 8'h00, {(i == 2) ? `CODE_DCP : code, 5'h1D});
      end
      done = 1'b0;
      wr(8'h02, 8'h85);
      chk("charger drive", {1'b0, auto_ctl}, {1'b0, ctl_out});
      done = 1'b1;
      for (int i = 0; i < 7; i++) begin
         wr(8'h02, 8'h80 | (8'h01 << i));
         chk("charger drive", 8'h01 << i, {1'b0, ctl_out});
      end
      rchk("control", 8'h02, 8'hC0);
      auto_ctl = 7'h55;
      wr(8'h02, 8'h7F);
      chk("charger drive", {1'b0, auto_ctl}, {1'b0, ctl_out});
      for (int i = 0; i < 2; i++) begin
         chs_in = (i == 0) ? 4'h5 : 4'hA;
         host.wt(6);
         rchk("chg status", 8'h03, {4'h0, chs_in});
      end
      wr(8'h11, 8'h44);
      wr(8'h00, 8'h00);
      wr(8'h05, 8'h00);
      wr(8'h03, 8'hFF);
      rchk("config", 8'h01, 8'h44);
      rchk("chg status", 8'h03, 8'h0A);
      rchk("unmapped", 8'h07, 8'hFF);
      rchk("unmapped", 8'h13, 8'hFF);
      host.wt(HOLD + 10);
      chk("int line", 8'h01, {7'h0, int_oe_n});
      ovlo = 1'b0;
      host.wt(6);
      chk("int line", 8'h00, {7'h0, int_oe_n});
      rchk("status", 8'h00, 8'h5E);
      chk("int line", 8'h01, {7'h0, int_oe_n});
      rchk("status", 8'h00, 8'h5C);
      ovlo = 1'b1;
      host.wt(6);
      while (int_oe_n === 1'b0 && n < 2 * HOLD) begin
         host.wt(1);
         n++;
      end
      chk("int hold", 8'h01, {7'h0, n >= HOLD - 8 && n <= HOLD});
      wr(8'h01, 8'hA0);
      host.wt(POR + 20);
      chk("restart span", 8'(POR), 8'(por_cnt));
      rchk("config", 8'h01, 8'h20);
      wr(8'h01, 8'h4D);
      rst = 1'b1;
      host.wt(16);
      chk("reset ports", 8'h03, {4'h0, sw, lim, int_oe_n, sda_oe_n});
      chk("pin values", 8'h00, {6'h0, sda_o, int_o});
      rst = 1'b0;
      host.wt(8);
      rchk("config", 8'h01, 8'h20);
      wrap_up();
   end
endmodule : tb_prot_charger_regs

//--- verilog/prot_charger_regs.sv
// Purpose: I2C target and register bank of a VBUS protection and charger detection block
// Assumes: RST is the VBUS undervoltage reset; LINK_CLK oversamples SCL and SDA
// Notes:   config and control registers live in the link domain; status registers and analog-facing logic in the REF_CLK domain
`timescale 1ns/100ps
`include "prot_charger_defs.svh"

module prot_charger_regs #(
   parameter int INT_HOLD_CYC = `INT_HOLD_NS / `REF_PERIOD_NS,
   parameter int SOFT_POR_CYC = `SOFT_POR_NS / `REF_PERIOD_NS
) (
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       LINK_CLK,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output      logic       SDA_O,
   output      logic       SDA_OE_N,
   output      logic       INT_O,
   output      logic       INT_OE_N,
   input  wire logic [1:0] OTP_ADDR,
   input  wire logic       OVERVOLTAGE_COMPARATOR_FLAG,
   input  wire logic       DETECTION_DONE_FLAG,
   input  wire logic [2:0] DETECTED_PORT_CODE,
   input  wire logic       EXTENDED_DETECTION_OPTION,
   input  wire logic       AUTO_SWITCH_ENABLE,
   input  wire logic       AUTO_LIMIT_ENABLE,
   input  wire logic [6:0] AUTO_CHARGER_CONTROL,
   input  wire logic [3:0] CHARGER_STATUS_IN,
   output      logic       PROTECTION_SWITCH_ENABLE,
   output      logic       LIMIT_ACTIVE,
   output      logic       FIRST_PATH_ENABLE,
   output      logic       SECOND_PATH_ENABLE,
   output      logic [6:0] CHARGER_CONTROL,
   output      logic       DETECTION_RESTART
);

   if (INT_HOLD_CYC < 1 || INT_HOLD_CYC >= (1 << 24)) begin : g_chk_int
      $error("INT_HOLD_CYC out of range");
   end
   if (SOFT_POR_CYC < 1 || SOFT_POR_CYC >= (1 << 24)) begin : g_chk_por
      $error("SOFT_POR_CYC out of range");
   end

   prot_charger_pkg::link_state_t l_q, l_d;
   prot_charger_pkg::ref_state_t  r_q, r_d;

   // ---------------- link domain: I2C target and register storage
   always_comb begin
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic [7:0] rd_val;
      rise   = 1'b0;
      fall   = 1'b0;
      start  = 1'b0;
      stop   = 1'b0;
      rd_val = `UNMAPPED_DATA;
      l_d = l_q;
      l_d.scl_m  = SCL_I;
      l_d.scl_s  = l_q.scl_m;
      l_d.scl_p  = l_q.scl_s;
      l_d.sda_m  = SDA_I;
      l_d.sda_s  = l_q.sda_m;
      l_d.sda_p  = l_q.sda_s;
      l_d.otp_m  = OTP_ADDR;
      l_d.otp_s  = l_q.otp_m;
      l_d.sts_m  = r_q.status;
      l_d.sts_s  = l_q.sts_m;
      l_d.chs_m  = r_q.chsts;
      l_d.chs_s  = l_q.chs_m;
      l_d.done_m = r_q.done_tgl;
      l_d.done_s = l_q.done_m;
      l_d.done_p = l_q.done_s;
      rise  = l_q.scl_s & ~l_q.scl_p;
      fall  = ~l_q.scl_s & l_q.scl_p;
      start = l_q.scl_s & l_q.scl_p & ~l_q.sda_s & l_q.sda_p;
      stop  = l_q.scl_s & l_q.scl_p & l_q.sda_s & ~l_q.sda_p;
      unique case (l_q.shreg)
         {4'h0, `REG_STATUS}: rd_val = l_q.sts_s;
         {4'h0, `REG_CONFIG}: rd_val = l_q.cfg;
         {4'h0, `REG_CHGCTL}: rd_val = l_q.ctl;
         {4'h0, `REG_CHGSTS}: rd_val = l_q.chs_s;
         default:             rd_val = `UNMAPPED_DATA;
      endcase
      if (l_q.done_s != l_q.done_p) begin
         l_d.cfg = `CFG_RESET;
         l_d.ctl = `CTL_RESET;
      end
      if (start) begin
         l_d.phase  = prot_charger_pkg::PH_ADDR;
         l_d.bitcnt = 4'h0;
         l_d.ack    = 1'b0;
         l_d.drive  = 1'b0;
      end else if (stop) begin
         l_d.phase = prot_charger_pkg::PH_IDLE;
         l_d.ack   = 1'b0;
         l_d.drive = 1'b0;
      end else if (rise) begin
         if (l_q.ack) begin
            if (l_q.phase == prot_charger_pkg::PH_RDAT) begin
               l_d.nxt = l_q.sda_s ? prot_charger_pkg::PH_SKIP : prot_charger_pkg::PH_REG;
            end
         end else if (l_q.phase != prot_charger_pkg::PH_IDLE &&
                      l_q.phase != prot_charger_pkg::PH_SKIP) begin
            l_d.shreg  = {l_q.shreg[6:0], l_q.sda_s};
            l_d.bitcnt = l_q.bitcnt + 4'h1;
         end
      end else if (fall) begin
         if (l_q.ack) begin
            l_d.ack    = 1'b0;
            l_d.bitcnt = 4'h0;
            l_d.phase  = l_q.nxt;
            l_d.drive  = 1'b0;
            if (l_q.nxt == prot_charger_pkg::PH_RDAT) begin
               l_d.drive = ~l_q.tx[7];
               l_d.tx    = {l_q.tx[6:0], 1'b1};
            end
         end else if (l_q.bitcnt == 4'h8) begin
            l_d.ack = 1'b1;
            unique case (l_q.phase)
               prot_charger_pkg::PH_ADDR: begin
                  if (l_q.shreg[7:1] == {`ADDR_FIXED, l_q.otp_s}) begin
                     l_d.drive = 1'b1;
                     l_d.rw    = l_q.shreg[0];
                     l_d.nxt   = prot_charger_pkg::PH_REG;
                  end else begin
                     l_d.ack   = 1'b0;
                     l_d.phase = prot_charger_pkg::PH_SKIP;
                  end
               end
               prot_charger_pkg::PH_REG: begin
                  l_d.drive   = 1'b1;
                  l_d.regaddr = l_q.shreg;
                  l_d.tx      = rd_val;
                  l_d.nxt     = l_q.rw ? prot_charger_pkg::PH_RDAT : prot_charger_pkg::PH_WDAT;
                  if (l_q.rw && l_q.shreg == {4'h0, `REG_STATUS}) begin
                     l_d.rd_tgl = ~l_q.rd_tgl;
                  end
               end
               prot_charger_pkg::PH_WDAT: begin
                  l_d.drive = 1'b1;
                  l_d.nxt   = prot_charger_pkg::PH_REG;
                  if (l_q.regaddr[3:0] == `REG_CONFIG) begin
                     l_d.cfg = l_q.shreg;
                  end else if (l_q.regaddr[3:0] == `REG_CHGCTL) begin
                     l_d.ctl = l_q.shreg;
                  end
               end
               prot_charger_pkg::PH_RDAT: begin
                  l_d.drive = 1'b0;
                  l_d.nxt   = prot_charger_pkg::PH_SKIP;
               end
               default: begin
                  l_d.ack = 1'b0;
               end
            endcase
         end else if (l_q.phase == prot_charger_pkg::PH_RDAT) begin
            l_d.drive = ~l_q.tx[7];
            l_d.tx    = {l_q.tx[6:0], 1'b1};
         end
      end
   end

   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         l_q         <= '0;
         l_q.scl_m   <= 1'b1;
         l_q.scl_s   <= 1'b1;
         l_q.scl_p   <= 1'b1;
         l_q.sda_m   <= 1'b1;
         l_q.sda_s   <= 1'b1;
         l_q.sda_p   <= 1'b1;
         l_q.phase   <= prot_charger_pkg::PH_IDLE;
         l_q.nxt     <= prot_charger_pkg::PH_IDLE;
         l_q.cfg     <= `CFG_RESET;
         l_q.ctl     <= `CTL_RESET;
      end else begin
         l_q <= l_d;
      end
   end

   // ---------------- ref domain: synchronisers, status, outputs, timers
   // cfg and ctl cross as plain levels; a write may show a mixed byte for one
   // cycle, which the analog side tolerates far better than added latency
   always_comb begin
      logic       ovlo;
      logic       done;
      logic [2:0] code;
      logic       ext;
      logic       rd_evt;
      logic       ovlo_evt;
      logic       manual;
      ovlo = r_q.in_s[18];
      done = r_q.in_s[17];
      code = r_q.in_s[16:14];
      ext  = r_q.in_s[13];
      rd_evt   = r_q.rd_s ^ r_q.rd_p;
      ovlo_evt = ovlo ^ r_q.ovlo_p;
      manual   = r_q.ctl_s[`CTL_MANUAL] & done;
      r_d = r_q;
      r_d.in_m  = {OVERVOLTAGE_COMPARATOR_FLAG, DETECTION_DONE_FLAG, DETECTED_PORT_CODE,
                   EXTENDED_DETECTION_OPTION, AUTO_SWITCH_ENABLE, AUTO_LIMIT_ENABLE,
                   AUTO_CHARGER_CONTROL, CHARGER_STATUS_IN};
      r_d.in_s  = r_q.in_m;
      r_d.cfg_m = l_q.cfg;
      r_d.cfg_s = r_q.cfg_m;
      r_d.ctl_m = l_q.ctl;
      r_d.ctl_s = r_q.ctl_m;
      r_d.rd_m  = l_q.rd_tgl;
      r_d.rd_s  = r_q.rd_m;
      r_d.rd_p  = r_q.rd_s;
      r_d.ovlo_p = ovlo;
      if (ovlo_evt) begin
         r_d.latch = 1'b1;
      end else if (rd_evt) begin
         r_d.latch = 1'b0;
      end
      r_d.sw_en  = r_q.cfg_s[`CFG_SW_OVR] ? r_q.cfg_s[`CFG_SW_EN] : r_q.in_s[12];
      r_d.lim_on = r_q.cfg_s[`CFG_LIM_OVR] ? r_q.cfg_s[`CFG_LIM_EN] : r_q.in_s[11];
      r_d.path1  = r_q.cfg_s[`CFG_PATH1] & done & ovlo;
      r_d.path2  = r_q.cfg_s[`CFG_PATH2] & done & ovlo;
      r_d.chg_out = manual ? r_q.ctl_s[6:0] : r_q.in_s[10:4];
      if (r_q.sr_busy) begin
         r_d.latch   = 1'b0;
         r_d.sw_en   = 1'b0;
         r_d.path1   = 1'b0;
         r_d.path2   = 1'b0;
         r_d.chg_out = 7'h00;
      end
      r_d.status = {(!ext && code == `CODE_CDP) ? `CODE_DCP : code,
                    done, r_d.lim_on, ~r_d.sw_en, r_d.latch, ovlo};
      r_d.chsts  = {4'h0, r_q.in_s[3:0]};
      // a change seen while the line is low restarts the hold time
      if (r_q.sr_busy) begin
         r_d.int_low = 1'b0;
      end else if (((r_d.status ^ r_q.status) & `STS_CHANGE_MASK) != 8'h00) begin
         r_d.int_low = 1'b1;
         r_d.int_cnt = 24'(INT_HOLD_CYC - 1);
      end else if (r_q.int_low && (rd_evt || r_q.int_cnt == 24'h000000)) begin
         r_d.int_low = 1'b0;
      end else if (r_q.int_low) begin
         r_d.int_cnt = r_q.int_cnt - 24'h000001;
      end
      if (r_q.sr_busy) begin
         if (r_q.sr_cnt == 24'h000000) begin
            r_d.sr_busy  = 1'b0;
            r_d.sr_wait  = 1'b1;
            r_d.done_tgl = ~r_q.done_tgl;
         end else begin
            r_d.sr_cnt = r_q.sr_cnt - 24'h000001;
         end
      end else if (r_q.sr_wait) begin
         r_d.sr_wait = r_q.cfg_s[`CFG_RESTART];
      end else if (r_q.cfg_s[`CFG_RESTART]) begin
         r_d.sr_busy = 1'b1;
         r_d.sr_cnt  = 24'(SOFT_POR_CYC - 1);
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         r_q         <= '0;
         r_q.cfg_m   <= `CFG_RESET;
         r_q.cfg_s   <= `CFG_RESET;
         // comparator starts at its idle level, so leaving reset fakes no event
         r_q.in_m[18] <= 1'b1;
         r_q.in_s[18] <= 1'b1;
         r_q.ovlo_p   <= 1'b1;
         r_q.status   <= `STS_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign SDA_O                    = 1'b0;
   assign SDA_OE_N                 = ~l_q.drive;
   assign INT_O                    = 1'b0;
   assign INT_OE_N                 = ~r_q.int_low;
   assign PROTECTION_SWITCH_ENABLE = r_q.sw_en;
   assign LIMIT_ACTIVE             = r_q.lim_on;
   assign FIRST_PATH_ENABLE        = r_q.path1;
   assign SECOND_PATH_ENABLE       = r_q.path2;
   assign CHARGER_CONTROL          = r_q.chg_out;
   assign DETECTION_RESTART        = r_q.sr_busy;

   // ---------------- checks
   logic ref_rd_evt;
   logic ref_ov_evt;
   assign ref_rd_evt = r_q.rd_s ^ r_q.rd_p;
   assign ref_ov_evt = r_q.in_s[18] ^ r_q.ovlo_p;

   AST_LATCH_SET: assert property (@(posedge REF_CLK) disable iff (RST)
      ref_ov_evt && !r_q.sr_busy |=> r_q.latch && r_q.status[1])
      else $error("overvoltage event not latched");
   AST_LATCH_READ_CLR: assert property (@(posedge REF_CLK) disable iff (RST)
      ref_rd_evt && !ref_ov_evt |=> !r_q.latch)
      else $error("status read did not clear latch");
   AST_SWITCH_STATUS: assert property (@(posedge REF_CLK) disable iff (RST)
      r_q.status[2] == !PROTECTION_SWITCH_ENABLE)
      else $error("switch status bit disagrees with switch");
   AST_LIMIT_OVR: assert property (@(posedge REF_CLK) disable iff (RST)
      $stable(r_q.cfg_s) && r_q.cfg_s[3] |=> LIMIT_ACTIVE == $past(r_q.cfg_s[1]))
      else $error("limit not following override");
   AST_CDP_AS_DCP: assert property (@(posedge REF_CLK) disable iff (RST)
      !r_q.in_s[13] && r_q.in_s[16:14] == 3'h2 |=> r_q.status[7:5] == 3'h1)
      else $error("charging port not reported as dedicated");
   AST_PATH_GATED: assert property (@(posedge REF_CLK) disable iff (RST)
      FIRST_PATH_ENABLE |-> $past(r_q.cfg_s[5]) && !$past(r_q.sr_busy))
      else $error("path enabled without its bit");
   AST_MANUAL_SRC: assert property (@(posedge REF_CLK) disable iff (RST)
      !r_q.ctl_s[7] && !r_q.sr_busy |=> CHARGER_CONTROL == $past(r_q.in_s[10:4]))
      else $error("charger circuits not driven by detection logic");
   AST_INT_READ_REL: assert property (@(posedge REF_CLK) disable iff (RST)
      r_q.int_low && ref_rd_evt && r_d.status == r_q.status |=> INT_OE_N)
      else $error("interrupt not released on status read");
   AST_RESTART_END: assert property (@(posedge REF_CLK) disable iff (RST)
      r_q.sr_busy && r_q.sr_cnt == 24'h000000 |=> !DETECTION_RESTART ##0
      (r_q.done_tgl != $past(r_q.done_tgl)))
      else $error("restart interval did not end");
   AST_ADDR_ACK: assert property (@(posedge LINK_CLK) disable iff (RST)
      l_q.phase == prot_charger_pkg::PH_ADDR && !l_q.ack && l_q.bitcnt == 4'h8 &&
      !l_q.scl_s && l_q.scl_p &&
      l_q.shreg[7:1] == {5'h1A, l_q.otp_s} |=> !SDA_OE_N && l_q.ack)
      else $error("own address not acknowledged");
   AST_UNMAPPED_FF: assert property (@(posedge LINK_CLK) disable iff (RST)
      l_q.phase == prot_charger_pkg::PH_REG && l_q.ack && l_q.rw &&
      l_q.regaddr > 8'h03 |-> l_q.tx == 8'hFF)
      else $error("undefined register did not read FF");
   AST_RO_WRITE_IGNORED: assert property (@(posedge LINK_CLK) disable iff (RST)
      l_q.phase == prot_charger_pkg::PH_WDAT && !l_q.ack && l_q.bitcnt == 4'h8 &&
      l_q.regaddr[3:0] != `REG_CONFIG && l_q.regaddr[3:0] != `REG_CHGCTL &&
      l_q.done_s == l_q.done_p |=> $stable(l_q.cfg) && $stable(l_q.ctl))
      else $error("write to read-only or undefined register took effect");

   COV_STATUS_READ: cover property (@(posedge REF_CLK) disable iff (RST) ref_rd_evt);
   COV_INT_TIMEOUT: cover property (@(posedge REF_CLK) disable iff (RST)
      r_q.int_low && r_q.int_cnt == 24'h000000 ##1 INT_OE_N);
   COV_RESTART: cover property (@(posedge REF_CLK) disable iff (RST) $fell(r_q.sr_busy));
   COV_CFG_WRITE: cover property (@(posedge LINK_CLK) disable iff (RST)
      l_q.cfg != $past(l_q.cfg));

endmodule : prot_charger_regs
